// *** design/pcie_device_control_status.sv ***
// device control and device status registers with their side effects
// assumes configuration accesses are 16 bits wide at byte offsets
// 98h and 9ah and that all inputs are synchronous to core_clk_i
`timescale 1ns/1ps
`default_nettype none

// Summary of operation
// R1: retry completion on forwarded config time-out
// R2: retry disabled by default, then never issued
// R3: read request cap from 3-bit code
// R4: prefetch from read cap and cache line
// R5: no-snoop bit copied for non-VC0 requests
// R6: aux PM enable writable, no effect
// R7: aux PM enable survives warm reset
// R8: phantom, extended tag, relaxed ordering read zero
// R9: payload cap from 3-bit code
// R10: unsupported request sends nonfatal message when enabled
// R11: fatal events send fatal message when enabled
// R12: nonfatal events send nonfatal message when enabled
// R13: correctable events send correctable message when enabled
// R14: pending bit while non-posted requests outstanding
// R15: status shows aux power presence
// R16: unsupported request seen bit set on receipt
// R17: fatal error seen bit set on detection
// R18: nonfatal error seen bit set on detection
// R19: correctable error seen bit set on detection
// R20: upper ten status bits read zero
// R21: write one clears a seen bit
module pcie_device_control_status (
    input wire logic core_clk_i,
    input wire logic sys_rst_i,
    input wire logic sticky_rst_i,
    input wire logic cfg_wr_i,
    input wire logic cfg_rd_i,
    input wire logic [7:0] cfg_addr_i,
    input wire logic [1:0] cfg_be_i,
    input wire logic [15:0] cfg_wdata_i,
    output logic [15:0] cfg_rdata_o,
    output logic cfg_rvalid_o,
    input wire logic [7:0] cache_line_dw_i,
    input wire logic fwd_start_i,
    input wire logic fwd_done_i,
    output logic retry_cpl_o,
    input wire logic np_issue_i,
    input wire logic np_done_i,
    input wire logic aux_power_present_i,
    input wire logic ur_rcvd_i,
    input wire logic fatal_err_i,
    input wire logic nonfatal_err_i,
    input wire logic corr_err_i,
    input wire logic up_req_nonvc0_i,
    output logic up_no_snoop_o,
    output logic [12:0] read_limit_o,
    output logic [12:0] payload_limit_o,
    output logic [12:0] prefetch_bytes_o,
    output logic msg_fatal_o,
    output logic msg_nonfatal_o,
    output logic msg_cor_o
);

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef struct packed {
        logic [15:0] ctrl;
        logic [3:0] seen;
        logic [7:0] np_cnt;
        logic aux_det;
        devctl_pkg::fwd_state_t fwd;
        logic [7:0] tmo_cnt;
        logic [15:0] rdata;
        logic rvalid;
        logic retry_cpl;
        logic no_snoop;
        logic [12:0] rd_lim;
        logic [12:0] pay_lim;
        logic [12:0] pref;
        logic msg_fatal;
        logic msg_nonfatal;
        logic msg_cor;
    } state_t;

    state_t st_reg;
    state_t st_next;
    devctl_if link ();
    logic ctrl_wr;
    logic stat_wr;
    logic [3:0] seen_clr;
    logic [3:0] seen_set;
    logic [15:0] stat_val;

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    request_sizer u_sizer (
        .sz(link)
    );

    error_reporter u_reporter (
        .rp(link)
    );

    // settings and events handed to the helpers
    assign link.rd_req_code = st_reg.ctrl[devctl_pkg::RD_REQ_LSB +: 3];
    assign link.payload_code = st_reg.ctrl[devctl_pkg::PAYLOAD_LSB +: 3];
    assign link.cache_line_dw = cache_line_dw_i;
    assign link.ur_rep = st_reg.ctrl[devctl_pkg::UR_REP_BIT];
    assign link.fatal_rep = st_reg.ctrl[devctl_pkg::FATAL_REP_BIT];
    assign link.nonfatal_rep = st_reg.ctrl[devctl_pkg::NONFATAL_REP_BIT];
    assign link.cor_rep = st_reg.ctrl[devctl_pkg::COR_REP_BIT];
    assign link.ev_ur = ur_rcvd_i;
    assign link.ev_fatal = fatal_err_i;
    assign link.ev_nonfatal = nonfatal_err_i;
    assign link.ev_cor = corr_err_i;

    // ------------------------------------------------------------
    // access decode and status image
    // ------------------------------------------------------------
    assign ctrl_wr = cfg_wr_i && (cfg_addr_i == devctl_pkg::CTRL_OFF);
    assign stat_wr = cfg_wr_i && (cfg_addr_i == devctl_pkg::STAT_OFF);
    assign seen_clr = (stat_wr && cfg_be_i[0]) ? cfg_wdata_i[3:0]
        : 4'h0; // see R21
    assign seen_set = {ur_rcvd_i, fatal_err_i, // see R16 R17
        nonfatal_err_i, corr_err_i}; // see R18 R19
    assign stat_val = {10'h000, // see R20
        (st_reg.np_cnt != 8'h00), // see R14
        st_reg.aux_det, // see R15
        st_reg.seen};

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        st_next = st_reg;
        st_next.rvalid = 1'b0;
        st_next.retry_cpl = 1'b0;

        // byte-wise control write; unbacked bits stay zero
        if (ctrl_wr) begin
            for (int b = 0; b < 2; b++) begin
                if (cfg_be_i[b]) begin
                    st_next.ctrl[b*8 +: 8] = cfg_wdata_i[b*8 +: 8]; // see R6
                end
            end
        end
        st_next.ctrl = st_next.ctrl & devctl_pkg::CTRL_IMPL_MASK; // see R8

        // a new event wins over a clear in the same cycle
        st_next.seen = (st_reg.seen & ~seen_clr) | seen_set; // see R16

        // outstanding non-posted requests
        if (np_issue_i && !np_done_i) begin
            st_next.np_cnt = st_reg.np_cnt + 8'h01; // see R14
        end else if (np_done_i && !np_issue_i && st_reg.np_cnt != 8'h00) begin
            st_next.np_cnt = st_reg.np_cnt - 8'h01; // see R14
        end

        st_next.aux_det = aux_power_present_i; // see R15

        // read answer one cycle after the request
        if (cfg_rd_i) begin
            st_next.rvalid = 1'b1;
            case (cfg_addr_i)
                devctl_pkg::CTRL_OFF: st_next.rdata = st_reg.ctrl;
                devctl_pkg::STAT_OFF: st_next.rdata = stat_val;
                default: st_next.rdata = 16'h0000;
            endcase
        end

        // forwarded configuration request watchdog
        case (st_reg.fwd)
            devctl_pkg::FWD_IDLE: begin
                if (fwd_start_i) begin
                    st_next.fwd = devctl_pkg::FWD_WAIT;
                    st_next.tmo_cnt = 8'h00;
                end
            end
            devctl_pkg::FWD_WAIT: begin
                if (fwd_done_i) begin
                    st_next.fwd = devctl_pkg::FWD_IDLE;
                end else if (st_reg.tmo_cnt == devctl_pkg::RETRY_LAST) begin
                    if (st_reg.ctrl[devctl_pkg::RETRY_EN_BIT]) begin
                        st_next.retry_cpl = 1'b1; // see R1
                        st_next.fwd = devctl_pkg::FWD_DRAIN;
                    end
                    // disabled: keep waiting, no retry answer, see R2
                end else begin
                    st_next.tmo_cnt = st_reg.tmo_cnt + 8'h01;
                end
            end
            devctl_pkg::FWD_DRAIN: begin
                // late secondary completion is discarded
                if (fwd_done_i) begin
                    st_next.fwd = devctl_pkg::FWD_IDLE;
                end
            end
            default: st_next.fwd = devctl_pkg::FWD_IDLE;
        endcase

        // registered outputs
        st_next.no_snoop = up_req_nonvc0_i
            && st_reg.ctrl[devctl_pkg::NO_SNOOP_BIT]; // see R5
        st_next.rd_lim = link.read_limit; // see R3
        st_next.pay_lim = link.payload_limit; // see R9
        st_next.pref = link.prefetch; // see R4
        st_next.msg_fatal = link.msg_fatal; // see R11
        st_next.msg_nonfatal = link.msg_nonfatal; // see R10
        st_next.msg_cor = link.msg_cor; // see R13

        // warm reset keeps the aux PM enable unless a cold reset too
        if (sys_rst_i) begin
            st_next = '0;
            st_next.ctrl = devctl_pkg::CTRL_RST;
            st_next.seen = devctl_pkg::STAT_RST[3:0];
            st_next.fwd = devctl_pkg::FWD_IDLE;
            st_next.rd_lim = devctl_pkg::size_bytes(
                devctl_pkg::CTRL_RST[devctl_pkg::RD_REQ_LSB +: 3]);
            st_next.pay_lim = devctl_pkg::size_bytes(
                devctl_pkg::CTRL_RST[devctl_pkg::PAYLOAD_LSB +: 3]);
            st_next.pref = st_next.rd_lim;
            if (!sticky_rst_i) begin
                st_next.ctrl[devctl_pkg::AUX_PM_BIT] =
                    st_reg.ctrl[devctl_pkg::AUX_PM_BIT]; // see R7
            end
        end
    end

    // ------------------------------------------------------------
    // state register
    // ------------------------------------------------------------
    always_ff @(posedge core_clk_i) begin
        st_reg <= st_next;
    end

    // ports straight from the state register
    assign cfg_rdata_o = st_reg.rdata;
    assign cfg_rvalid_o = st_reg.rvalid;
    assign retry_cpl_o = st_reg.retry_cpl;
    assign up_no_snoop_o = st_reg.no_snoop;
    assign read_limit_o = st_reg.rd_lim;
    assign payload_limit_o = st_reg.pay_lim;
    assign prefetch_bytes_o = st_reg.pref;
    assign msg_fatal_o = st_reg.msg_fatal;
    assign msg_nonfatal_o = st_reg.msg_nonfatal;
    assign msg_cor_o = st_reg.msg_cor;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge core_clk_i);
    endclocking
    default disable iff (sys_rst_i);

    retry_fires_a: assert property ( // see R1
        st_reg.fwd == devctl_pkg::FWD_WAIT && !fwd_done_i
        && st_reg.tmo_cnt == devctl_pkg::RETRY_LAST
        && st_reg.ctrl[devctl_pkg::RETRY_EN_BIT] |=> retry_cpl_o)
        else $error("retry completion missing after time-out");

    retry_gate_a: assert property ( // see R2
        retry_cpl_o |-> $past(st_reg.ctrl[devctl_pkg::RETRY_EN_BIT])
        && $past(st_reg.tmo_cnt) == devctl_pkg::RETRY_LAST)
        else $error("retry completion while disabled");

    read_cap_a: assert property ( // see R3
        ##1 read_limit_o == devctl_pkg::size_bytes(
            $past(st_reg.ctrl[devctl_pkg::RD_REQ_LSB +: 3])))
        else $error("read request cap wrong");

    payload_cap_a: assert property ( // see R9
        ##1 payload_limit_o == devctl_pkg::size_bytes(
            $past(st_reg.ctrl[devctl_pkg::PAYLOAD_LSB +: 3])))
        else $error("payload cap wrong");

    no_snoop_a: assert property ( // see R5
        up_req_nonvc0_i ##1 !sys_rst_i |-> up_no_snoop_o
        == $past(st_reg.ctrl[devctl_pkg::NO_SNOOP_BIT]))
        else $error("no-snoop flag wrong");

    ro_zero_a: assert property ( // see R8
        cfg_rd_i && cfg_addr_i == devctl_pkg::CTRL_OFF
        |=> cfg_rvalid_o && cfg_rdata_o[9:8] == 2'b00
        && !cfg_rdata_o[4])
        else $error("read-only control bits not zero");

    stat_rsvd_a: assert property ( // see R20
        cfg_rd_i && cfg_addr_i == devctl_pkg::STAT_OFF
        |=> cfg_rvalid_o && cfg_rdata_o[15:6] == 10'h000)
        else $error("reserved status bits not zero");

    seen_set_a: assert property ( // see R16
        ur_rcvd_i |=> st_reg.seen[3] [*1])
        else $error("unsupported request not recorded");

    w1c_clear_a: assert property ( // see R21
        stat_wr && cfg_be_i[0] && cfg_wdata_i[0] && !corr_err_i
        |=> !st_reg.seen[0])
        else $error("correctable seen bit not cleared");

    outstanding_hold_a: assert property ( // see R14
        np_issue_i && !np_done_i ##1 !np_done_i
        |-> st_reg.np_cnt != 8'h00)
        else $error("pending flag lost");

    ur_msg_a: assert property ( // see R10
        ur_rcvd_i && st_reg.ctrl[devctl_pkg::UR_REP_BIT]
        |=> msg_nonfatal_o)
        else $error("unsupported request not reported");

    sticky_keep_a: assert property ( // see R7
        $fell(sys_rst_i) && !$past(sticky_rst_i)
        |-> st_reg.ctrl[devctl_pkg::AUX_PM_BIT]
        == $past(st_reg.ctrl[devctl_pkg::AUX_PM_BIT]))
        else $error("aux PM enable lost in warm reset");

endmodule
`default_nettype wire

// *** design/devctl_pkg.sv ***
// constants, types and size decode for the device control/status pair
// assumes a 125 MHz core clock and 16-bit configuration accesses
package devctl_pkg;

    // ------------------------------------------------------------
    // register map
    // ------------------------------------------------------------
    localparam logic [7:0] CTRL_OFF = 8'h98;
    localparam logic [7:0] STAT_OFF = 8'h9a;
    localparam logic [15:0] CTRL_RST = 16'h2800;
    localparam logic [15:0] STAT_RST = 16'h0000;
    // bits that hold state; 9, 8 and 4 read as zero
    localparam logic [15:0] CTRL_IMPL_MASK = 16'hfcef;

    // ------------------------------------------------------------
    // control field positions
    // ------------------------------------------------------------
    localparam int RETRY_EN_BIT = 15;
    localparam int RD_REQ_LSB = 12;
    localparam int NO_SNOOP_BIT = 11;
    localparam int AUX_PM_BIT = 10;
    localparam int PAYLOAD_LSB = 5;
    localparam int UR_REP_BIT = 3;
    localparam int FATAL_REP_BIT = 2;
    localparam int NONFATAL_REP_BIT = 1;
    localparam int COR_REP_BIT = 0;

    // ------------------------------------------------------------
    // status field positions
    // ------------------------------------------------------------
    localparam int NP_OUTSTANDING_BIT = 5;
    localparam int AUX_DET_BIT = 4;
    localparam int SEEN_W = 4;

    // ------------------------------------------------------------
    // sizes and timing
    // ------------------------------------------------------------
    localparam logic [2:0] SIZE_CODE_MAX = 3'h5;
    localparam logic [12:0] SIZE_BASE_BYTES = 13'h080;
    localparam int CLK_PERIOD_NS = 8;
    localparam int RETRY_TIMEOUT_NS = 1000;
    localparam int RETRY_CYCLES =
        (RETRY_TIMEOUT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [7:0] RETRY_LAST = 8'(RETRY_CYCLES - 1);

    // forwarded configuration request tracker
    typedef enum logic [1:0] {
        FWD_IDLE = 2'b00,
        FWD_WAIT = 2'b01,
        FWD_DRAIN = 2'b11
    } fwd_state_t;

    // byte count of a size code; reserved codes fall back to the least
    function automatic logic [12:0] size_bytes(input logic [2:0] code);
        if (code > SIZE_CODE_MAX) begin
            return SIZE_BASE_BYTES;
        end
        return 13'(SIZE_BASE_BYTES << code);
    endfunction

endpackage

// *** design/devctl_if.sv ***
// settings and results passed between the register bank and helpers
// assumes all members are sampled on the core clock by the bank
`timescale 1ns/1ps
`default_nettype none
interface devctl_if;
    logic [2:0] rd_req_code;
    logic [2:0] payload_code;
    logic [7:0] cache_line_dw;
    logic [12:0] read_limit;
    logic [12:0] payload_limit;
    logic [12:0] prefetch;
    logic ur_rep;
    logic fatal_rep;
    logic nonfatal_rep;
    logic cor_rep;
    logic ev_ur;
    logic ev_fatal;
    logic ev_nonfatal;
    logic ev_cor;
    logic msg_fatal;
    logic msg_nonfatal;
    logic msg_cor;

    modport bank (output rd_req_code, payload_code, cache_line_dw, ur_rep,
        fatal_rep, nonfatal_rep, cor_rep, ev_ur, ev_fatal, ev_nonfatal,
        ev_cor, input read_limit, payload_limit, prefetch, msg_fatal,
        msg_nonfatal, msg_cor);
    modport sizer (input rd_req_code, payload_code, cache_line_dw,
        output read_limit, payload_limit, prefetch);
    modport reporter (input ur_rep, fatal_rep, nonfatal_rep, cor_rep,
        ev_ur, ev_fatal, ev_nonfatal, ev_cor,
        output msg_fatal, msg_nonfatal, msg_cor);
endinterface
`default_nettype wire

// *** design/request_sizer.sv ***
// size limits and prefetch amount from the programmed codes
// assumes the bank registers the results before they leave the block
`timescale 1ns/1ps
`default_nettype none
module request_sizer (
    devctl_if.sizer sz
);
    logic [12:0] line_bytes;

    // ------------------------------------------------------------
    // decode and prefetch choice
    // ------------------------------------------------------------
    always_comb begin
        line_bytes = {3'h0, sz.cache_line_dw, 2'b00};
        sz.read_limit = devctl_pkg::size_bytes(sz.rd_req_code); // see R3
        sz.payload_limit = devctl_pkg::size_bytes(sz.payload_code); // see R9
        // one cache line, capped by the read request limit
        if (line_bytes == 13'h000 || line_bytes > sz.read_limit) begin
            sz.prefetch = sz.read_limit; // see R4
        end else begin
            sz.prefetch = line_bytes; // see R4
        end
    end
endmodule
`default_nettype wire

// *** design/error_reporter.sv ***
// error message requests gated by the reporting enables
// assumes event inputs are single-cycle pulses
`timescale 1ns/1ps
`default_nettype none
module error_reporter (
    devctl_if.reporter rp
);
    // ------------------------------------------------------------
    // message gating
    // ------------------------------------------------------------
    always_comb begin
        rp.msg_fatal = rp.ev_fatal & rp.fatal_rep; // see R11
        rp.msg_nonfatal = (rp.ev_nonfatal & rp.nonfatal_rep) // see R12
            | (rp.ev_ur & rp.ur_rep); // see R10
        rp.msg_cor = rp.ev_cor & rp.cor_rep; // see R13
    end
endmodule
`default_nettype wire

// *** verif/sec_bus_model.sv ***
// secondary-bus responder for configuration requests forwarded by the block
// assumes one request at a time and a start pulse on the core clock
`timescale 1ns/1ps
`default_nettype none
module sec_bus_model (
    input wire logic clk_i,
    input wire logic start_i,
    input wire logic [15:0] delay_i,
    output logic done_o
);
    // idle at time zero, no request in flight
    logic [15:0] cnt_reg = 16'h0000;
    logic busy_reg = 1'b0;

    // answer delay_i + 1 cycles after the start, with a one-cycle done
    always @(posedge clk_i) begin
        done_o <= 1'b0;
        if (start_i && !busy_reg) begin
            busy_reg <= 1'b1;
            cnt_reg <= delay_i;
        end else if (busy_reg) begin
            if (cnt_reg == 16'h0000) begin
                busy_reg <= 1'b0;
                done_o <= 1'b1;
            end else begin
                cnt_reg <= cnt_reg - 16'h0001;
            end
        end
    end
endmodule
`default_nettype wire

// *** verif/pcie_device_control_status_tb.sv ***
// self-checking bench for the device control and status registers
// assumes inputs change on the falling edge and a 125 MHz clock
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, got) begin comparisons++; if ((got) !== (ex)) begin \
    err_count++; $display("[ERR] %s exp %h got %h", nm, ex, got); end end
module pcie_device_control_status_tb;
    logic clk = 0, rst = 1, sticky = 1, wr = 0, rd = 0;
    logic [7:0] addr = 8'h00, cl_dw = 8'h00;
    logic [1:0] be = 2'h0;
    logic [15:0] wdata = 16'h0000, delay = 16'h000a, d;
    logic [15:0] rdata;
    logic rvalid, fwd_start = 0, fwd_done, retry, np_issue = 0, np_done = 0;
    logic aux = 0, nonvc0 = 0, nosnoop, mf, mnf, mc;
    logic [3:0] evs = 4'h0;
    logic [12:0] rlim, plim, pf;
    logic [7:0] c_f, c_nf, c_c, c_r, c_ns;
    logic cnt_clr = 1'b1;
    int err_count = 0;
    int comparisons = 0;

    // ------------------------------------------------------------
    // clock, design and far side
    // ------------------------------------------------------------
    initial begin
        forever #4 clk = ~clk;
    end

    pcie_device_control_status dut_u (.core_clk_i(clk), .sys_rst_i(rst),
        .sticky_rst_i(sticky), .cfg_wr_i(wr), .cfg_rd_i(rd),
        .cfg_addr_i(addr), .cfg_be_i(be), .cfg_wdata_i(wdata),
        .cfg_rdata_o(rdata), .cfg_rvalid_o(rvalid),
        .cache_line_dw_i(cl_dw), .fwd_start_i(fwd_start),
        .fwd_done_i(fwd_done), .retry_cpl_o(retry), .np_issue_i(np_issue),
        .np_done_i(np_done), .aux_power_present_i(aux),
        .ur_rcvd_i(evs[3]), .fatal_err_i(evs[2]), .nonfatal_err_i(evs[1]),
        .corr_err_i(evs[0]), .up_req_nonvc0_i(nonvc0),
        .up_no_snoop_o(nosnoop), .read_limit_o(rlim),
        .payload_limit_o(plim), .prefetch_bytes_o(pf), .msg_fatal_o(mf),
        .msg_nonfatal_o(mnf), .msg_cor_o(mc));

    sec_bus_model model_u (.clk_i(clk), .start_i(fwd_start),
        .delay_i(delay), .done_o(fwd_done));

    // counts one-cycle output pulses; cnt_clr empties the counters
    always @(posedge clk) begin
        if (cnt_clr) begin
            {c_f, c_nf, c_c, c_r, c_ns} <= 40'h0;
        end else begin
            c_f <= c_f + 8'(mf);
            c_nf <= c_nf + 8'(mnf);
            c_c <= c_c + 8'(mc);
            c_r <= c_r + 8'(retry);
            c_ns <= c_ns + 8'(nosnoop);
        end
    end

    // ------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------
    task automatic wrap_up;
        if (err_count == 0 && comparisons > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    task automatic cyc(input int n);
        repeat (n) @(negedge clk);
    endtask

    task automatic clr;
        @(negedge clk);
        cnt_clr = 1;
        @(negedge clk);
        cnt_clr = 0;
    endtask

    task automatic reset(input logic st);
        @(negedge clk);
        sticky = st;
        rst = 1;
        cyc(3);
        rst = 0;
    endtask

    task automatic cfg_wr(input logic [7:0] a, input logic [1:0] b,
                          input logic [15:0] v);
        @(negedge clk);
        {wr, addr, be, wdata} = {1'b1, a, b, v};
        @(negedge clk);
        wr = 0;
    endtask

    // read, then wait a bounded time for the answer
    task automatic cfg_rd(input logic [7:0] a, output logic [15:0] v);
        int i;
        @(negedge clk);
        {rd, addr} = {1'b1, a};
        @(negedge clk);
        rd = 0;
        for (i = 0; i < 4 && rvalid !== 1'b1; i++) begin
            @(posedge clk);
            #1;
        end
        if (rvalid !== 1'b1) begin
            err_count++;
            wrap_up();
        end
        v = rdata;
    endtask

    task automatic chk_rd(input logic [7:0] a, input logic [15:0] ex);
        cfg_rd(a, d);
        `CHK("cfg_rdata", ex, d)
    endtask

    task automatic pulse(ref logic s);
        @(negedge clk);
        s = 1;
        @(negedge clk);
        s = 0;
    endtask

    task automatic ev(input int i);
        @(negedge clk);
        evs[i] = 1;
        @(negedge clk);
        evs = 4'h0;
    endtask

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_defaults;
        chk_rd(8'h98, 16'h2800);
        chk_rd(8'h9a, 16'h0000);
        chk_rd(8'h9c, 16'h0000);
        `CHK("read_limit", 13'h200, rlim)
        `CHK("payload_limit", 13'h080, plim)
    endtask

    task automatic t_fields;
        logic [2:0] c;
        cfg_wr(8'h98, 2'h3, 16'hffff);
        chk_rd(8'h98, 16'hfcef);
        cfg_wr(8'h9a, 2'h3, 16'hffff);
        chk_rd(8'h9a, 16'h0000);
        `CHK("read_limit", 13'h080, rlim)
        `CHK("payload_limit", 13'h080, plim)
        for (int i = 0; i < 6; i++) begin
            c = i[2:0];
            cfg_wr(8'h98, 2'h3, {1'b0, c, 4'h0, c, 5'h00});
            cyc(3);
            `CHK("read_limit", 13'h080 << i, rlim)
            `CHK("payload_limit", 13'h080 << i, plim)
        end
    endtask

    task automatic t_prefetch;
        cfg_wr(8'h98, 2'h3, 16'h0800);
        cl_dw = 8'h08;
        cyc(3);
        `CHK("prefetch", 13'h020, pf)
        cl_dw = 8'h40;
        cyc(3);
        `CHK("prefetch", 13'h080, pf)
        cl_dw = 8'h00;
        cyc(3);
        `CHK("prefetch", 13'h080, pf)
    endtask

    task automatic t_no_snoop;
        cfg_wr(8'h98, 2'h3, 16'h2800);
        clr();
        pulse(nonvc0);
        cyc(3);
        `CHK("no_snoop", 8'h01, c_ns)
        cfg_wr(8'h98, 2'h3, 16'h2000);
        clr();
        pulse(nonvc0);
        cyc(3);
        `CHK("no_snoop", 8'h00, c_ns)
    endtask

    // each event with reporting off, then on; seen bits cleared by one
    task automatic t_errors;
        for (int i = 3; i >= 0; i--) begin
            cfg_wr(8'h98, 2'h3, 16'h2800);
            clr();
            ev(i);
            cyc(3);
            chk_rd(8'h9a, 16'h1 << i);
            `CHK("msg_count", 24'h0, {c_f, c_nf, c_c})
            cfg_wr(8'h9a, 2'h1, 16'h0000);
            chk_rd(8'h9a, 16'h1 << i);
            cfg_wr(8'h9a, 2'h1, 16'h1 << i);
            chk_rd(8'h9a, 16'h0000);
            cfg_wr(8'h98, 2'h3, 16'h2800 | (16'h1 << i));
            clr();
            ev(i);
            cyc(3);
            `CHK("msg_fatal", 8'(i == 2), c_f)
            `CHK("msg_nonfatal", 8'(i == 3 || i == 1), c_nf)
            `CHK("msg_cor", 8'(i == 0), c_c)
            cfg_wr(8'h9a, 2'h1, 16'h000f);
        end
    endtask

    task automatic t_status;
        pulse(np_issue);
        pulse(np_issue);
        pulse(np_done);
        chk_rd(8'h9a, 16'h0020);
        pulse(np_done);
        chk_rd(8'h9a, 16'h0000);
        aux = 1;
        cyc(2);
        chk_rd(8'h9a, 16'h0010);
        aux = 0;
        cyc(2);
        chk_rd(8'h9a, 16'h0000);
    endtask

    task automatic t_sticky;
        cfg_wr(8'h98, 2'h3, 16'h2c00);
        reset(1'b0);
        chk_rd(8'h98, 16'h2c00);
        reset(1'b1);
        chk_rd(8'h98, 16'h2800);
    endtask

    // slow far side with retry off, then on; prompt far side with it on
    task automatic t_retry;
        delay = 16'h00c8;
        clr();
        pulse(fwd_start);
        cyc(210);
        `CHK("retry_cpl", 8'h00, c_r)
        cfg_wr(8'h98, 2'h3, 16'ha800);
        clr();
        pulse(fwd_start);
        cyc(120);
        `CHK("retry_cpl", 8'h00, c_r)
        cyc(10);
        `CHK("retry_cpl", 8'h01, c_r)
        cyc(80);
        delay = 16'h000a;
        clr();
        pulse(fwd_start);
        cyc(140);
        `CHK("retry_cpl", 8'h00, c_r)
    endtask

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        cyc(3);
        rst = 0;
        t_defaults();
        t_fields();
        t_prefetch();
        t_no_snoop();
        t_errors();
        t_status();
        t_sticky();
        t_retry();
        wrap_up();
    end
endmodule
`default_nettype wire
